// [logic/eubs_pkg.sv]
package eubs_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_SERIAL_CONTROL_REG = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_SERIAL_STATUS_REG = 8'h08;
   localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h0C;
   localparam logic [7:0] OFS_DIVL = 8'h10;
   localparam logic [7:0] OFS_DIVH = 8'h14;
   localparam logic [7:0] OFS_BSEL = 8'h18;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SC_MODE_HI = 7;
   localparam int SC_MODE_LO = 6;
   localparam int SC_MC = 5;
   localparam int SC_REN = 4;
   localparam int SC_TB8 = 3;
   localparam int SC_RB8 = 2;
   localparam int SC_TI = 1;
   localparam int SC_RI = 0;
   localparam int ST_DBUF = 7;
   localparam int ST_FE = 3;
   localparam int ST_BRK = 2;
   localparam int PC_BDBL = 7;
   localparam int PC_FES = 6;
   localparam int BS_BRG = 0;
   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0000;
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [3:0] BITS_M0 = 4'h8;
   localparam logic [3:0] BITS_8 = 4'hA;
   localparam logic [3:0] BITS_9 = 4'hB;
   localparam logic [3:0] STOP_IDX_8 = 4'h9;
   localparam logic [3:0] STOP_IDX_9 = 4'hA;
   localparam logic [7:0] BREAK_TICKS = 8'hB0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_FIX9 = 2'h2;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_FRAME = 3'b010,
      TX_SHIFT = 3'b100
   } eubs_tx_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b01,
      RX_FRAME = 2'b10
   } eubs_rx_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_en;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sm_hi;
      logic sm_lo;
      logic sm2;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
      logic double_buffer_enable;
      logic fe;
      logic brk;
      logic bdbl;
      logic fes;
      logic use_brg;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [7:0] rxbuf;
      logic [15:0] brg_cnt;
      logic t1_half;
      logic m2_half;
      logic os_tick;
      eubs_tx_t tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [3:0] tx_os;
      logic tx_pend;
      logic [7:0] tx_pbyte;
      logic tx_p9;
      logic m0_rx;
      logic txd;
      logic rxd_o;
      logic rxd_oe_n;
      eubs_rx_t rx_st;
      logic [3:0] rx_os;
      logic [3:0] rx_cnt;
      logic [8:0] rx_sh;
      logic [7:0] low_cnt;
   } eubs_state_t;
endpackage

// [logic/eubs_uart.sv]
`timescale 1ns/1ps
module eubs_uart
   import eubs_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_rxd,
   input wire logic i_t1_ovf,
   input wire logic i_osc_tick,
   output logic o_txd,
   output logic o_rxd_out,
   output logic o_rxd_oe_n
);
   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (ADDR_W < 8) begin : g_chk
      $error("eubs_uart needs ADDR_W of at least 8");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == OFS_SERIAL_CONTROL_REG) || (a == OFS_DATA) || (a == OFS_SERIAL_STATUS_REG) || (a == OFS_POWER_CONTROL_REG) ||
                (a == OFS_DIVL) || (a == OFS_DIVH) || (a == OFS_BSEL);
   endfunction

   eubs_state_t s_ff;
   eubs_state_t nxt_s;
   logic [1:0] mode;
   logic mode9;
   logic dbuf_on;
   logic brg_hit;
   logic t1_hit;
   logic m2_hit;
   logic wr_do;
   logic [7:0] serial_control_reg_rd;

   assign mode = {s_ff.sm_hi, s_ff.sm_lo};
   assign mode9 = s_ff.sm_hi;
   assign dbuf_on = s_ff.double_buffer_enable && (mode != MODE_SHIFT);
   assign brg_hit = i_osc_tick && (s_ff.brg_cnt >= {s_ff.div_hi, s_ff.div_lo});
   assign t1_hit = i_t1_ovf && (s_ff.bdbl || s_ff.t1_half);
   assign m2_hit = s_ff.bdbl || s_ff.m2_half;
   assign wr_do = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
   // Bit 7 doubles as framing error view; the stored mode bit is untouched meanwhile
   assign serial_control_reg_rd = {(s_ff.fes ? s_ff.fe : s_ff.sm_hi), s_ff.sm_lo, s_ff.sm2, s_ff.ren,
                     s_ff.tb8, s_ff.rb8, s_ff.ti, s_ff.ri};

   always_comb begin
      logic tx_wr;
      logic [7:0] d;
      logic [7:0] rb;
      tx_wr = 1'b0;
      d = s_ff.w_data;
      rb = BYTE_RST;
      nxt_s = s_ff;

      // ---------------------------------------------------------------
      // Baud tick generation, 16 ticks per bit
      // ---------------------------------------------------------------
      if (i_osc_tick) begin
         nxt_s.brg_cnt = brg_hit ? DIV_RST : s_ff.brg_cnt + 16'h0001;
      end
      if (i_t1_ovf) begin
         nxt_s.t1_half = ~s_ff.t1_half;
      end
      nxt_s.m2_half = ~s_ff.m2_half;
      // Fixed rate only for the first 9-bit mode; Timer 2 has no path here
      if (mode == MODE_FIX9) begin
         nxt_s.os_tick = m2_hit;
      end else begin
         nxt_s.os_tick = s_ff.use_brg ? brg_hit : t1_hit;
      end

      // ---------------------------------------------------------------
      // AXI4-Lite write channel
      // ---------------------------------------------------------------
      if (i_awvalid && s_ff.awready) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.aw_addr = i_awaddr[7:0];
      end
      if (i_wvalid && s_ff.wready) begin
         nxt_s.w_got = 1'b1;
         nxt_s.w_data = i_wdata[7:0];
         nxt_s.w_en = i_wstrb[0];
      end
      if (s_ff.bvalid && i_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (wr_do) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = reg_hit(s_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_do && s_ff.w_en) begin
         case (s_ff.aw_addr)
            OFS_SERIAL_CONTROL_REG: begin
               if (s_ff.fes) begin
                  if (!d[SC_MODE_HI]) begin
                     nxt_s.fe = 1'b0;
                  end
               end else begin
                  nxt_s.sm_hi = d[SC_MODE_HI];
               end
               nxt_s.sm_lo = d[SC_MODE_LO];
               nxt_s.sm2 = d[SC_MC];
               nxt_s.ren = d[SC_REN];
               nxt_s.tb8 = d[SC_TB8];
               nxt_s.rb8 = d[SC_RB8];
               nxt_s.ti = d[SC_TI];
               nxt_s.ri = d[SC_RI];
            end
            OFS_DATA: begin
               tx_wr = 1'b1;
            end
            OFS_SERIAL_STATUS_REG: begin
               nxt_s.double_buffer_enable = d[ST_DBUF];
               if (d[ST_FE]) begin
                  nxt_s.fe = 1'b0;
               end
               if (d[ST_BRK]) begin
                  nxt_s.brk = 1'b0;
               end
            end
            OFS_POWER_CONTROL_REG: begin
               nxt_s.bdbl = d[PC_BDBL];
               nxt_s.fes = d[PC_FES];
            end
            OFS_DIVL: begin
               nxt_s.div_lo = d;
            end
            OFS_DIVH: begin
               nxt_s.div_hi = d;
            end
            OFS_BSEL: begin
               nxt_s.use_brg = d[BS_BRG];
            end
            default: begin
            end
         endcase
      end
      nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
      nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

      // ---------------------------------------------------------------
      // AXI4-Lite read channel
      // ---------------------------------------------------------------
      if (s_ff.rvalid && i_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (i_arvalid && s_ff.arready) begin
         case (i_araddr[7:0])
            OFS_SERIAL_CONTROL_REG: rb = serial_control_reg_rd;
            OFS_DATA: rb = s_ff.rxbuf;
            OFS_SERIAL_STATUS_REG: rb = {s_ff.double_buffer_enable, 3'h0, s_ff.fe, s_ff.brk, 2'h0};
            OFS_POWER_CONTROL_REG: rb = {s_ff.bdbl, s_ff.fes, 6'h00};
            OFS_DIVL: rb = s_ff.div_lo;
            OFS_DIVH: rb = s_ff.div_hi;
            OFS_BSEL: rb = {7'h00, s_ff.use_brg};
            default: rb = BYTE_RST;
         endcase
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = {24'h000000, rb};
         nxt_s.rresp = reg_hit(i_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
      end
      nxt_s.arready = !nxt_s.rvalid;

      // ---------------------------------------------------------------
      // Transmit holding slot
      // ---------------------------------------------------------------
      // Single buffer takes a byte only when the line is idle; later writes are dropped
      if (tx_wr && !s_ff.tx_pend && (dbuf_on || s_ff.tx_st == TX_IDLE)) begin
         nxt_s.tx_pend = 1'b1;
         nxt_s.tx_pbyte = d;
         nxt_s.tx_p9 = s_ff.tb8;
      end

      // ---------------------------------------------------------------
      // Transmitter and shift-register engine
      // ---------------------------------------------------------------
      case (s_ff.tx_st)
         TX_IDLE: begin
            if (s_ff.tx_pend) begin
               nxt_s.tx_pend = 1'b0;
               nxt_s.tx_os = 4'h0;
               nxt_s.m0_rx = 1'b0;
               if (mode == MODE_SHIFT) begin
                  nxt_s.tx_st = TX_SHIFT;
                  nxt_s.tx_sh = {3'h7, s_ff.tx_pbyte};
                  nxt_s.tx_cnt = BITS_M0;
                  nxt_s.txd = 1'b0;
                  nxt_s.rxd_o = s_ff.tx_pbyte[0];
                  nxt_s.rxd_oe_n = 1'b0;
               end else begin
                  nxt_s.tx_st = TX_FRAME;
                  if (mode9) begin
                     nxt_s.tx_sh = {1'b1, s_ff.tx_p9, s_ff.tx_pbyte, 1'b0};
                     nxt_s.tx_cnt = BITS_9;
                  end else begin
                     nxt_s.tx_sh = {2'h3, s_ff.tx_pbyte, 1'b0};
                     nxt_s.tx_cnt = BITS_8;
                  end
                  nxt_s.txd = 1'b0;
                  // With double buffering the slot is free again as soon as it loads
                  if (dbuf_on) begin
                     nxt_s.ti = 1'b1;
                  end
               end
            end else if (mode == MODE_SHIFT && s_ff.ren && !s_ff.ri) begin
               nxt_s.tx_st = TX_SHIFT;
               nxt_s.tx_cnt = BITS_M0;
               nxt_s.tx_os = 4'h0;
               nxt_s.m0_rx = 1'b1;
               nxt_s.txd = 1'b0;
               nxt_s.rxd_oe_n = 1'b1;
            end
         end
         TX_FRAME: begin
            if (s_ff.os_tick) begin
               nxt_s.tx_os = s_ff.tx_os + 4'h1;
               if (s_ff.tx_os == OS_LAST) begin
                  if (s_ff.tx_cnt == 4'h1) begin
                     nxt_s.tx_st = TX_IDLE;
                     nxt_s.txd = 1'b1;
                     if (!dbuf_on) begin
                        nxt_s.ti = 1'b1;
                     end
                  end else begin
                     nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
                     nxt_s.txd = s_ff.tx_sh[1];
                     nxt_s.tx_cnt = s_ff.tx_cnt - 4'h1;
                  end
               end
            end
         end
         TX_SHIFT: begin
            // One bit per 16 CPU clocks; transmit pin is low then high each bit
            nxt_s.tx_os = s_ff.tx_os + 4'h1;
            nxt_s.txd = nxt_s.tx_os[3];
            if (s_ff.tx_os == OS_LAST) begin
               if (s_ff.m0_rx) begin
                  nxt_s.rx_sh = {i_rxd, s_ff.rx_sh[8:1]};
               end
               if (s_ff.tx_cnt == 4'h1) begin
                  nxt_s.tx_st = TX_IDLE;
                  nxt_s.txd = 1'b1;
                  nxt_s.rxd_oe_n = 1'b1;
                  if (s_ff.m0_rx) begin
                     nxt_s.rxbuf = nxt_s.rx_sh[8:1];
                     nxt_s.ri = 1'b1;
                  end else begin
                     nxt_s.ti = 1'b1;
                  end
               end else begin
                  nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
                  nxt_s.rxd_o = s_ff.tx_sh[1];
                  nxt_s.tx_cnt = s_ff.tx_cnt - 4'h1;
               end
            end
         end
         default: begin
            nxt_s.tx_st = TX_IDLE;
         end
      endcase

      // ---------------------------------------------------------------
      // Frame receiver, mid-bit sampling on the 16x tick
      // ---------------------------------------------------------------
      case (s_ff.rx_st)
         RX_IDLE: begin
            if (s_ff.os_tick && s_ff.ren && !i_rxd && mode != MODE_SHIFT) begin
               nxt_s.rx_st = RX_FRAME;
               nxt_s.rx_os = 4'h0;
               nxt_s.rx_cnt = 4'h0;
            end
         end
         RX_FRAME: begin
            if (mode == MODE_SHIFT) begin
               nxt_s.rx_st = RX_IDLE;
            end else if (s_ff.os_tick) begin
               nxt_s.rx_os = s_ff.rx_os + 4'h1;
               if (s_ff.rx_os == OS_MID) begin
                  if (s_ff.rx_cnt == 4'h0) begin
                     // A glitch shorter than half a bit is not a start bit
                     if (i_rxd) begin
                        nxt_s.rx_st = RX_IDLE;
                     end else begin
                        nxt_s.rx_cnt = 4'h1;
                     end
                  end else if (s_ff.rx_cnt == (mode9 ? STOP_IDX_9 : STOP_IDX_8)) begin
                     nxt_s.rx_st = RX_IDLE;
                     nxt_s.ri = 1'b1;
                     if (mode9) begin
                        nxt_s.rxbuf = s_ff.rx_sh[7:0];
                        nxt_s.rb8 = s_ff.rx_sh[8];
                     end else begin
                        nxt_s.rxbuf = s_ff.rx_sh[8:1];
                        nxt_s.rb8 = i_rxd;
                     end
                     if (!i_rxd) begin
                        nxt_s.fe = 1'b1;
                     end
                  end else begin
                     nxt_s.rx_sh = {i_rxd, s_ff.rx_sh[8:1]};
                     nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
                  end
               end
            end
         end
         default: begin
            nxt_s.rx_st = RX_IDLE;
         end
      endcase

      // ---------------------------------------------------------------
      // Break detect, counted in 16x ticks and saturating
      // ---------------------------------------------------------------
      if (s_ff.os_tick && mode != MODE_SHIFT) begin
         if (i_rxd) begin
            nxt_s.low_cnt = 8'h00;
         end else if (s_ff.low_cnt != BREAK_TICKS) begin
            nxt_s.low_cnt = s_ff.low_cnt + 8'h01;
            if (s_ff.low_cnt == BREAK_TICKS - 8'h01) begin
               nxt_s.brk = 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_ff <= '0;
         s_ff.awready <= 1'b1;
         s_ff.wready <= 1'b1;
         s_ff.arready <= 1'b1;
         s_ff.tx_st <= TX_IDLE;
         s_ff.rx_st <= RX_IDLE;
         s_ff.txd <= 1'b1;
         s_ff.rxd_o <= 1'b1;
         s_ff.rxd_oe_n <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_awready = s_ff.awready;
   assign o_wready = s_ff.wready;
   assign o_bresp = s_ff.bresp;
   assign o_bvalid = s_ff.bvalid;
   assign o_arready = s_ff.arready;
   assign o_rdata = s_ff.rdata;
   assign o_rresp = s_ff.rresp;
   assign o_rvalid = s_ff.rvalid;
   assign o_txd = s_ff.txd;
   assign o_rxd_out = s_ff.rxd_o;
   assign o_rxd_oe_n = s_ff.rxd_oe_n;
endmodule

// [testbench/eubs_uart_properties.sv]
`timescale 1ns/1ps
module eubs_uart_chk (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic o_txd,
   input wire logic o_rxd_oe_n
);
   // ---------------------------------------------------------------
   // Bus handshake and line timing
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);
   AST_AW_TAKE: assert property (i_awvalid && o_awready |=> !o_awready)
      else $error("awready high after address take");
   AST_B_ANSWER: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
      else $error("write response not two edges after take");
   AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before bready");
   AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
      else $error("write channel not free after response");
   AST_R_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read data not one edge after take");
   AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before rready");
   AST_R_TOP: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   // Fastest bit is 16 clocks, shift clock low phase is 8
   AST_START: assert property ($fell(o_txd) |-> !o_txd [*8])
      else $error("transmit low phase too short");
   AST_SHIFT_CLK: assert property ($fell(o_txd) && !o_rxd_oe_n |-> !o_txd [*8] ##1 o_txd)
      else $error("shift clock low phase not 8 cycles");
endmodule
bind eubs_uart eubs_uart_chk u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
   .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .i_rready(i_rready), .o_txd(o_txd), .o_rxd_oe_n(o_rxd_oe_n));

// [testbench/eubs_remote.sv]
`timescale 1ns/1ps
module eubs_remote (
   input wire logic i_core_clk,
   input wire logic i_txd,
   input wire logic i_pin,
   output logic o_line
);
   // Released line sits at the pull-up level
   initial o_line = 1'b1;
   task automatic send(input logic [11:0] f, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         o_line <= f[i];
         repeat (per) @(posedge i_core_clk);
      end
      o_line <= 1'b1;
   endtask
   // Samples mid-bit so a one-cycle start detect skew is harmless
   task automatic take(input int n, input int per, output logic [11:0] f);
      int k;
      k = 0;
      f = 12'h000;
      while (i_txd && k < 5000) begin
         @(posedge i_core_clk);
         k++;
      end
      repeat (per / 2) @(posedge i_core_clk);
      for (int i = 0; i < n; i++) begin
         f[i] = i_txd;
         if (i < n - 1) repeat (per) @(posedge i_core_clk);
      end
   endtask
   task automatic shift_in(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge i_txd);
         @(posedge i_core_clk);
         d[i] = i_pin;
      end
   endtask
endmodule

// [testbench/eubs_uart_tb.sv]
`timescale 1ns/1ps
module eubs_uart_tb import eubs_pkg::*;;
   logic i_core_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [7:0] i_awaddr = 8'h00;
   logic [7:0] i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_awvalid = 1'b0;
   logic i_wvalid = 1'b0;
   logic i_bready = 1'b0;
   logic i_arvalid = 1'b0;
   logic i_rready = 1'b0;
   logic i_t1_ovf = 1'b0;
   logic i_osc_tick = 1'b0;
   logic [1:0] tick_cnt = 2'h0;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] o_rdata;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_txd, o_rxd_out, o_rxd_oe_n, line;
   wire rxd_pin = o_rxd_oe_n ? line : o_rxd_out;
   int failures = 0;
   int compares = 0;
   logic [11:0] f;
   logic [7:0] d;
   logic [7:0] pc [5] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
   logic [7:0] sc [5] = '{8'h98, 8'h90, 8'h50, 8'h50, 8'hD8};
   int per [5] = '{16, 32, 64, 128, 96};
   eubs_uart DUT (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(4'hF), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
      .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .i_rxd(rxd_pin), .i_t1_ovf(i_t1_ovf),
      .i_osc_tick(i_osc_tick), .o_txd(o_txd), .o_rxd_out(o_rxd_out), .o_rxd_oe_n(o_rxd_oe_n));
   eubs_remote rem (.i_core_clk(i_core_clk), .i_txd(o_txd), .i_pin(rxd_pin), .o_line(line));
   always #4 i_core_clk = ~i_core_clk;
   // Oscillator tick every 2 cycles, timer overflow every 4
   always @(posedge i_core_clk) begin
      tick_cnt <= tick_cnt + 2'h1;
      i_osc_tick <= ~tick_cnt[0];
      i_t1_ovf <= tick_cnt == 2'h0;
   end
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Each valid drops only at the edge where its ready is sampled high
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
      int n;
      n = 0;
      i_awaddr <= a;
      i_wdata <= {24'h0, v};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid && n < 200);
      chk("bresp", {10'h0, er}, {10'h0, o_bresp});
      i_bready <= 1'b1;
      @(posedge i_core_clk);
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int n;
      n = 0;
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid && n < 200);
      chk($sformatf("reg %h", a), {4'h0, e}, o_rdata[11:0]);
      chk("rresp", {10'h0, (a > OFS_BSEL) ? RESP_SLVERR : RESP_OKAY}, {10'h0, o_rresp});
      i_rready <= 1'b1;
      @(posedge i_core_clk);
      i_rready <= 1'b0;
   endtask
   task automatic conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      @(posedge i_core_clk);
      for (int a = 0; a < 8; a++) rd(8'(a * 4), 8'h00);
      wr(8'h1C, 8'h55, RESP_SLVERR);
      wr(OFS_DIVL, 8'h02, RESP_OKAY);
      $display("test reset done");
      for (int c = 0; c < 5; c++) begin
         wr(OFS_POWER_CONTROL_REG, pc[c], RESP_OKAY);
         wr(OFS_BSEL, {7'h0, c == 4}, RESP_OKAY);
         wr(OFS_SERIAL_CONTROL_REG, sc[c], RESP_OKAY);
         d = 8'h5A ^ 8'(c * 37);
         wr(OFS_DATA, d, RESP_OKAY);
         rem.take(sc[c][7] ? 11 : 10, per[c], f);
         chk("frame", sc[c][7] ? {1'b0, 1'b1, sc[c][3], d, 1'b0} : {2'b00, 1'b1, d, 1'b0}, f);
         rem.send(sc[c][7] ? {1'b1, 1'b1, ~sc[c][3], ~d, 1'b0} : {2'b11, 1'b1, ~d, 1'b0}, 11, per[c]);
         rd(OFS_DATA, ~d);
         rd(OFS_SERIAL_CONTROL_REG, sc[c] | 8'h03 | {5'h0, sc[c][7] ? ~sc[c][3] : 1'b1, 2'h0});
         $display("test config %0d done", c);
      end
      wr(OFS_POWER_CONTROL_REG, 8'h80, RESP_OKAY);
      wr(OFS_BSEL, 8'h00, RESP_OKAY);
      wr(OFS_SERIAL_CONTROL_REG, 8'h50, RESP_OKAY);
      rem.send(12'h102, 10, 64);
      rd(OFS_SERIAL_STATUS_REG, 8'h08);
      rd(OFS_DATA, 8'h81);
      wr(OFS_POWER_CONTROL_REG, 8'hC0, RESP_OKAY);
      rd(OFS_SERIAL_CONTROL_REG, 8'hD1);
      wr(OFS_SERIAL_STATUS_REG, 8'h08, RESP_OKAY);
      rd(OFS_SERIAL_CONTROL_REG, 8'h51);
      wr(OFS_POWER_CONTROL_REG, 8'h80, RESP_OKAY);
      rem.send(12'h000, 12, 64);
      rd(OFS_SERIAL_STATUS_REG, 8'h0C);
      $display("test error done");
      wr(OFS_SERIAL_CONTROL_REG, 8'h98, RESP_OKAY);
      wr(OFS_SERIAL_STATUS_REG, 8'h8C, RESP_OKAY);
      wr(OFS_DATA, 8'h11, RESP_OKAY);
      wr(OFS_DATA, 8'h22, RESP_OKAY);
      rem.take(11, 16, f);
      chk("first", 12'h622, f);
      rem.take(11, 16, f);
      chk("second", 12'h644, f);
      wr(OFS_SERIAL_STATUS_REG, 8'h00, RESP_OKAY);
      wr(OFS_SERIAL_CONTROL_REG, 8'h00, RESP_OKAY);
      wr(OFS_DATA, 8'h6A, RESP_OKAY);
      rem.shift_in(d);
      chk("shift", 12'h06A, {4'h0, d});
      $display("test buffer and shift done");
      conclude();
   end
   initial begin
      repeat (60000) @(posedge i_core_clk);
      failures++;
      conclude();
   end
endmodule
